/* File: hdl/lslr_pkg.sv */
// constants for the line sensor readout and configuration block
package lslr_pkg;
  // pixel array and line timing
  localparam int unsigned NUM_PIXELS     = 1024;
  localparam logic [10:0] PIXEL_LIMIT    = 11'h400;
  localparam logic [7:0]  FIRST_WORD_EDGE = 8'h94;  // 148th falling strobe edge
  localparam logic [5:0]  INTEG_TAIL     = 6'h2b;   // 43 master clocks after rise
  localparam int unsigned WORD_BITS      = 12;
  // serial frame layout
  localparam logic [4:0]  SPI_HDR_BITS   = 5'h08;
  localparam logic [4:0]  SPI_FRAME_BITS = 5'h10;
  localparam int unsigned ADDR_BITS      = 7;
  // configuration addresses
  localparam logic [6:0]  ADDR_MODE      = 7'h01;
  localparam logic [6:0]  ADDR_WSTART_HI = 7'h0b;
  localparam logic [6:0]  ADDR_WSTART_LO = 7'h0c;
  localparam logic [6:0]  ADDR_WCOUNT_HI = 7'h0f;
  localparam logic [6:0]  ADDR_WCOUNT_LO = 7'h10;
  localparam logic [6:0]  ADDR_SKIP      = 7'h12;
  localparam logic [6:0]  ADDR_OFFSET    = 7'h16;
  // reset values
  localparam logic        RST_MODE       = 1'h0;
  localparam logic [10:0] RST_WSTART     = 11'h000;
  localparam logic [10:0] RST_WCOUNT     = 11'h400;
  localparam logic [1:0]  RST_SKIP       = 2'h0;
  localparam logic [3:0]  RST_OFFSET     = 4'h7;
  // pin synchroniser order and idle levels
  localparam int unsigned PIN_LINE = 0;
  localparam int unsigned PIN_SCLK = 1;
  localparam int unsigned PIN_CSN  = 2;
  localparam int unsigned PIN_MOSI = 3;
  localparam int unsigned PIN_CRSTN = 4;
  localparam logic [4:0]  PIN_IDLE = 5'h15;  // line start idles high, else a false rise follows reset
  // readout states
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_LEAD  = 2'b01,
    RD_VIDEO = 2'b10
  } lslr_rd_e;
endpackage

/* File: hdl/lslr_readout.sv */
// line sensor readout sequencer with serial configuration port
// Notes on behaviour
// - integration lasts the low time plus 43 clocks.
// - all pixels start integrating when line start falls.
// - integration ends 43 clocks after line start rise; readout follows the rise.
// - first word appears at the 148th falling strobe edge after the rise.
// - line sync rises together with the first video word.
// - words come out in pixel order from window start.
// - next integration may overlap readout of the previous line.
// - each pixel value is a 12-bit parallel word.
// - a pixel strobe output marks each video word.
// - mode bit at address 1: 0 normal, 1 low power; resets 0.
// - low power halts readout circuitry outside the video interval.
// - window start is 11 bits at addresses 11 and 12, default 0.
// - window count is 11 bits at addresses 15 and 16, default 1024.
// - two-bit skip count at address 18, default 0.
// - four-bit offset level at address 22, default 7.
// - config reset low restores every register default.
// - frame is 7 address bits, write flag, 8 data bits, MSB first.
// - register contents can be read back on MISO.
module lslr_readout #(
  parameter int unsigned WORD_W = lslr_pkg::WORD_BITS
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // line control pins
  input  wire logic              lineStartPulse,
  input  wire logic              configResetN,
  // serial configuration pins
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic              mosi,
  output logic                   miso,
  // converter side
  input  wire logic [WORD_W-1:0] adcWord,
  output logic [10:0]            pixelSel,
  output logic [3:0]             offsetLevel,
  output logic                   integrating,
  output logic                   readoutOn,
  // video outputs
  output logic [WORD_W-1:0]      videoWord,
  output logic                   wordValid,
  output logic                   pixStrobe,
  output logic                   lineSync
);

  // readback decode, shared by the serial read path
  function automatic logic [7:0] regRead(input logic [6:0] a, input logic m, input logic [10:0] ws,
                                         input logic [10:0] wc, input logic [1:0] sk, input logic [3:0] of);
    logic [7:0] r;
    r = 8'h00;
    if (a == lslr_pkg::ADDR_MODE) begin
      r = {7'h00, m};
    end else if (a == lslr_pkg::ADDR_WSTART_HI) begin
      r = {5'h00, ws[10:8]};
    end else if (a == lslr_pkg::ADDR_WSTART_LO) begin
      r = ws[7:0];
    end else if (a == lslr_pkg::ADDR_WCOUNT_HI) begin
      r = {5'h00, wc[10:8]};
    end else if (a == lslr_pkg::ADDR_WCOUNT_LO) begin
      r = wc[7:0];
    end else if (a == lslr_pkg::ADDR_SKIP) begin
      r = {6'h00, sk};
    end else if (a == lslr_pkg::ADDR_OFFSET) begin
      r = {4'h0, of};
    end
    return r;
  endfunction

  // pin synchronisers: a change counts once stages two and three agree
  logic [4:0] syncA_reg, syncB_reg, syncC_reg, pinClean_reg, pinPrev_reg;
  logic [4:0] pinClean_next;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pinClean_next[i] = (syncB_reg[i] == syncC_reg[i]) ? syncC_reg[i] : pinClean_reg[i];
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncA_reg    <= lslr_pkg::PIN_IDLE;
      syncB_reg    <= lslr_pkg::PIN_IDLE;
      syncC_reg    <= lslr_pkg::PIN_IDLE;
      pinClean_reg <= lslr_pkg::PIN_IDLE;
      pinPrev_reg  <= lslr_pkg::PIN_IDLE;
    end else begin
      syncA_reg    <= {configResetN, mosi, csN, sclk, lineStartPulse};
      syncB_reg    <= syncA_reg;
      syncC_reg    <= syncB_reg;
      pinClean_reg <= pinClean_next;
      pinPrev_reg  <= pinClean_reg;
    end
  end

  logic lineRise, lineFall, sclkRise, sclkFall, csActive, mosiBit, cfgRstN;
  assign lineRise = pinClean_reg[lslr_pkg::PIN_LINE] & ~pinPrev_reg[lslr_pkg::PIN_LINE];
  assign lineFall = ~pinClean_reg[lslr_pkg::PIN_LINE] & pinPrev_reg[lslr_pkg::PIN_LINE];
  assign sclkRise = pinClean_reg[lslr_pkg::PIN_SCLK] & ~pinPrev_reg[lslr_pkg::PIN_SCLK];
  assign sclkFall = ~pinClean_reg[lslr_pkg::PIN_SCLK] & pinPrev_reg[lslr_pkg::PIN_SCLK];
  assign csActive = ~pinClean_reg[lslr_pkg::PIN_CSN];
  assign mosiBit  = pinClean_reg[lslr_pkg::PIN_MOSI];
  assign cfgRstN  = pinClean_reg[lslr_pkg::PIN_CRSTN];

  // serial port and configuration registers
  logic        mode_reg, mode_next;
  logic [10:0] winStart_reg, winStart_next, winCount_reg, winCount_next;
  logic [1:0]  skip_reg, skip_next;
  logic [3:0]  offset_reg, offset_next;
  logic [4:0]  bitCnt_reg, bitCnt_next;
  logic [7:0]  shiftIn_reg, shiftIn_next, readShift_reg, readShift_next;
  logic        isRead_reg, isRead_next, miso_reg, miso_next, wrPulse;
  logic [6:0]  hdrAddr_reg, hdrAddr_next;
  logic [6:0]  wrAddr;
  logic [7:0]  wrData;
  always_comb begin
    mode_next      = mode_reg;
    winStart_next  = winStart_reg;
    winCount_next  = winCount_reg;
    skip_next      = skip_reg;
    offset_next    = offset_reg;
    bitCnt_next    = bitCnt_reg;
    shiftIn_next   = shiftIn_reg;
    readShift_next = readShift_reg;
    isRead_next    = isRead_reg;
    miso_next      = miso_reg;
    wrPulse        = 1'b0;
    wrAddr         = shiftIn_reg[7:1];
    wrData         = {shiftIn_reg[6:0], mosiBit};
    if (!csActive) begin
      bitCnt_next = 5'h00;
      isRead_next = 1'b0;
      miso_next   = 1'b0;
    end else if (sclkRise && bitCnt_reg < lslr_pkg::SPI_FRAME_BITS) begin
      shiftIn_next = {shiftIn_reg[6:0], mosiBit};
      bitCnt_next  = bitCnt_reg + 5'h01;
      if (bitCnt_reg == lslr_pkg::SPI_HDR_BITS - 5'h01) begin
        // header done: capture address, preload readback
        isRead_next    = ~mosiBit;
        readShift_next = regRead(shiftIn_reg[6:0], mode_reg, winStart_reg, winCount_reg, skip_reg, offset_reg);
        shiftIn_next   = {shiftIn_reg[6:0], mosiBit};
      end
      if (bitCnt_reg == lslr_pkg::SPI_FRAME_BITS - 5'h01 && !isRead_reg) begin
        wrPulse = 1'b1;
      end
    end else if (sclkFall && isRead_reg && bitCnt_reg >= lslr_pkg::SPI_HDR_BITS) begin
      miso_next      = readShift_reg[7]; // msb first on falling edges
      readShift_next = {readShift_reg[6:0], 1'b0};
    end
    // header byte was stored when bit 8 arrived, so address comes from hdrAddr_reg while the shift byte holds data
    if (bitCnt_reg >= lslr_pkg::SPI_HDR_BITS) begin
      wrAddr = hdrAddr_reg;
    end
    if (wrPulse) begin
      if (wrAddr == lslr_pkg::ADDR_MODE) begin
        mode_next = wrData[0];
      end else if (wrAddr == lslr_pkg::ADDR_WSTART_HI) begin
        winStart_next[10:8] = wrData[2:0];
      end else if (wrAddr == lslr_pkg::ADDR_WSTART_LO) begin
        winStart_next[7:0] = wrData;
      end else if (wrAddr == lslr_pkg::ADDR_WCOUNT_HI) begin
        winCount_next[10:8] = wrData[2:0];
      end else if (wrAddr == lslr_pkg::ADDR_WCOUNT_LO) begin
        winCount_next[7:0] = wrData;
      end else if (wrAddr == lslr_pkg::ADDR_SKIP) begin
        skip_next = wrData[1:0];
      end else if (wrAddr == lslr_pkg::ADDR_OFFSET) begin
        offset_next = wrData[3:0];
      end
    end
    // config reset pin overrides any write in flight
    if (!cfgRstN) begin
      mode_next     = lslr_pkg::RST_MODE;
      winStart_next = lslr_pkg::RST_WSTART;
      winCount_next = lslr_pkg::RST_WCOUNT;
      skip_next     = lslr_pkg::RST_SKIP;
      offset_next   = lslr_pkg::RST_OFFSET;
    end
  end
  assign hdrAddr_next = (csActive && sclkRise && bitCnt_reg == lslr_pkg::SPI_HDR_BITS - 5'h01)
                        ? shiftIn_reg[6:0] : hdrAddr_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_reg      <= lslr_pkg::RST_MODE;
      winStart_reg  <= lslr_pkg::RST_WSTART;
      winCount_reg  <= lslr_pkg::RST_WCOUNT;
      skip_reg      <= lslr_pkg::RST_SKIP;
      offset_reg    <= lslr_pkg::RST_OFFSET;
      bitCnt_reg    <= 5'h00;
      shiftIn_reg   <= 8'h00;
      readShift_reg <= 8'h00;
      isRead_reg    <= 1'b0;
      miso_reg      <= 1'b0;
      hdrAddr_reg   <= 7'h00;
    end else begin
      mode_reg      <= mode_next;
      winStart_reg  <= winStart_next;
      winCount_reg  <= winCount_next;
      skip_reg      <= skip_next;
      offset_reg    <= offset_next;
      bitCnt_reg    <= bitCnt_next;
      shiftIn_reg   <= shiftIn_next;
      readShift_reg <= readShift_next;
      isRead_reg    <= isRead_next;
      miso_reg      <= miso_next;
      hdrAddr_reg   <= hdrAddr_next;
    end
  end

  // integration window: fall opens, rise plus tail closes
  logic       integ_reg, integ_next;
  logic [5:0] tail_reg, tail_next;
  always_comb begin
    integ_next = integ_reg;
    tail_next  = tail_reg;
    if (lineFall) begin
      integ_next = 1'b1; // every pixel starts together
      tail_next  = 6'h00;
    end else if (lineRise) begin
      tail_next = lslr_pkg::INTEG_TAIL; // low time plus 43 clocks
    end else if (tail_reg != 6'h00) begin
      tail_next = tail_reg - 6'h01;
      if (tail_reg == 6'h01) begin
        integ_next = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      integ_reg <= 1'b0;
      tail_reg  <= 6'h00;
    end else begin
      integ_reg <= integ_next;
      tail_reg  <= tail_next;
    end
  end

  // readout: strobe runs at half rate, words change on its falling edge
  lslr_pkg::lslr_rd_e state_reg, state_next;
  logic [7:0]        edgeCnt_reg, edgeCnt_next;
  logic [10:0]       pixIdx_reg, pixIdx_next, left_reg, left_next, step;
  logic [WORD_W-1:0] video_reg, video_next;
  logic              strobe_reg, strobe_next, valid_reg, valid_next, sync_reg, sync_next, ron_reg, ron_next;
  logic              strobeFall;
  assign step       = {9'h000, skip_reg} + 11'h001; // skip k after each word
  assign strobeFall = strobe_reg & ~strobe_next;
  always_comb begin
    state_next   = state_reg;
    edgeCnt_next = edgeCnt_reg;
    pixIdx_next  = pixIdx_reg;
    left_next    = left_reg;
    video_next   = video_reg;
    valid_next   = valid_reg;
    sync_next    = sync_reg;
    strobe_next  = ~strobe_reg;
    if (lineRise) begin
      // readout of the captured line begins after the rise
      state_next   = lslr_pkg::RD_LEAD;
      edgeCnt_next = 8'h00;
      pixIdx_next  = winStart_reg;
      valid_next   = 1'b0;
      sync_next    = 1'b0;
    end else if (strobeFall) begin
      case (state_reg)
        lslr_pkg::RD_LEAD: begin
          edgeCnt_next = edgeCnt_reg + 8'h01;
          if (edgeCnt_next == lslr_pkg::FIRST_WORD_EDGE) begin
            if (winCount_reg == 11'h000 || pixIdx_reg >= lslr_pkg::PIXEL_LIMIT) begin
              state_next = lslr_pkg::RD_IDLE;
            end else begin
              state_next  = lslr_pkg::RD_VIDEO;
              video_next  = adcWord;
              valid_next  = 1'b1;
              sync_next   = 1'b1; // marks the first word
              pixIdx_next = pixIdx_reg + step;
              left_next   = winCount_reg - 11'h001;
            end
          end
        end
        lslr_pkg::RD_VIDEO: begin
          sync_next = 1'b0;
          if (left_reg == 11'h000 || pixIdx_reg >= lslr_pkg::PIXEL_LIMIT) begin
            state_next = lslr_pkg::RD_IDLE;
            valid_next = 1'b0;
          end else begin
            video_next  = adcWord;
            pixIdx_next = pixIdx_reg + step;
            left_next   = left_reg - 11'h001;
          end
        end
        default: begin
          valid_next = 1'b0;
        end
      endcase
    end
    // low power keeps readout circuitry off outside the video interval
    ron_next = ~mode_reg | (state_next == lslr_pkg::RD_VIDEO);
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg   <= lslr_pkg::RD_IDLE;
      edgeCnt_reg <= 8'h00;
      pixIdx_reg  <= 11'h000;
      left_reg    <= 11'h000;
      video_reg   <= '0;
      valid_reg   <= 1'b0;
      sync_reg    <= 1'b0;
      strobe_reg  <= 1'b0;
      ron_reg     <= 1'b1;
    end else begin
      state_reg   <= state_next;
      edgeCnt_reg <= edgeCnt_next;
      pixIdx_reg  <= pixIdx_next;
      left_reg    <= left_next;
      video_reg   <= video_next;
      valid_reg   <= valid_next;
      sync_reg    <= sync_next;
      strobe_reg  <= strobe_next;
      ron_reg     <= ron_next;
    end
  end

  // outputs straight from flops
  assign miso        = miso_reg;
  assign pixelSel    = pixIdx_reg;
  assign offsetLevel = offset_reg;
  assign integrating = integ_reg;
  assign readoutOn   = ron_reg;
  assign videoWord   = video_reg;
  assign wordValid   = valid_reg;
  assign pixStrobe   = strobe_reg;
  assign lineSync    = sync_reg;

  // checks
  sequence riseSeen_s;
    lineRise;
  endsequence
  sequence tailDone_s;
    ##43 integ_reg ##1 !integ_reg;
  endsequence
  first_word_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(sync_reg) |-> $past(edgeCnt_reg) == 8'h93) else $error("first word not at edge 148");
  sync_word_a: assert property (@(posedge mclk) disable iff (sys_rst)
    sync_reg |-> valid_reg && state_reg == lslr_pkg::RD_VIDEO) else $error("sync without first word");
  pixel_order_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg == lslr_pkg::RD_VIDEO && strobeFall && !lineRise && left_reg != 11'h000
     && pixIdx_reg < lslr_pkg::PIXEL_LIMIT) |=> pixIdx_reg == $past(pixIdx_reg) + $past(step))
    else $error("pixel index did not advance by step");
  integ_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
    lineFall |=> integ_reg) else $error("integration did not start on fall");
  integ_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
    riseSeen_s |-> tailDone_s) else $error("integration tail not 43 clocks");
  cfg_reset_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !cfgRstN |=> !mode_reg && offset_reg == 4'h7 && winCount_reg == 11'h400 && winStart_reg == 11'h000)
    else $error("config reset left a register changed");
  low_power_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (mode_reg && state_reg != lslr_pkg::RD_VIDEO && $past(mode_reg)) |-> !ron_reg)
    else $error("readout on outside video in low power");
  mode_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (wrPulse && wrAddr == lslr_pkg::ADDR_MODE && cfgRstN) |=> mode_reg == $past(wrData[0]))
    else $error("mode write not stored");
endmodule

/* File: bench/lslr_ctrl_model.sv */
// controller model: line start pulse and serial configuration master
module lslr_ctrl_model (
  // clock
  input  wire logic mclk,
  // line start and serial pins
  output logic      lineStartPulse,
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int fallCyc = 0;
  int riseCyc = 0;

  // idle pins at time zero, serial clock parked low outside frames
  initial begin
    lineStartPulse = 1'b1;
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end

  // free cycle count, the time base for every phase length
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one sixteen-bit frame, address, flag, then data, msb first
  task automatic frame(input logic [6:0] addr, input logic wr, input logic [7:0] din, output logic [7:0] dout);
    logic [15:0] bits;
    bits = {addr, wr, din};
    dout = 8'h00;
    csN <= 1'b0;
    ticks(8);
    for (int i = 15; i >= 0; i--) begin
      mosi <= bits[i];
      ticks(8);  // 80 ns half period keeps sclk at 6.25 MHz
      sclk <= 1'b1;
      if (i < 8) dout[i] = miso;  // read bits taken at the rising edge
      ticks(8);
      sclk <= 1'b0;
    end
    ticks(8);
    csN <= 1'b1;
    mosi <= ~mosi;  // released line must not show the stale bit
    ticks(8);
  endtask

  // lowering the pulse starts integration of all pixels
  task automatic fall();
    lineStartPulse <= 1'b0;
    fallCyc = cyc;
  endtask

  // raise after extra clocks, never before the minimum low and period spans
  task automatic rise(input int extra, input int nPix, output int lowSeen);
    ticks(extra);
    while (cyc - fallCyc < 64 || cyc - riseCyc < 138 + nPix) @(posedge mclk);
    lineStartPulse <= 1'b1;
    lowSeen = cyc - fallCyc;
    riseCyc = cyc;
    ticks(167);  // minimum high phase
  endtask
endmodule

/* File: bench/lslr_readout_test.sv */
// self-checking bench for the line readout sequencer and its serial port
module lslr_readout_test;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and pins
  logic        mclk         = 1'b0;
  logic        sys_rst      = 1'b1;
  logic        configResetN = 1'b1;
  logic [11:0] adcWord      = 12'h000;
  wire logic   lineStartPulse;
  wire logic   sclk;
  wire logic   csN;
  wire logic   mosi;
  logic        miso;
  logic [10:0] pixelSel;
  logic [3:0]  offsetLevel;
  logic        integrating;
  logic        readoutOn;
  logic [11:0] videoWord;
  logic        wordValid;
  logic        pixStrobe;
  logic        lineSync;
  // model state
  int          seed = 59;
  int          salt = 0;
  int          miscompares = 0;
  int          comparisons = 0;
  int          intRun = 0;
  bit          inVideo = 0;
  bit          phase = 0;
  bit          overlap = 0;
  logic        lastStrobe = 1'b0;
  logic [11:0] got[$];
  logic [11:0] expWords[$];
  int          intLens[$];
  logic [6:0]  regAddr[7] = '{7'h01, 7'h0b, 7'h0c, 7'h0f, 7'h10, 7'h12, 7'h16};
  logic [7:0]  regMask[7] = '{8'h01, 8'h07, 8'hff, 8'h07, 8'hff, 8'h03, 8'h0f};
  logic [7:0]  regRst[7]  = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h07};
  logic [7:0]  regVal[7];
  int          caseSt[5]  = '{0, 1000, 5, 1020, 1030};
  int          caseCnt[5] = '{1024, 30, 20, 3, 10};
  int          caseSk[5]  = '{0, 0, 3, 1, 1};

  always #5 mclk = ~mclk;

  lslr_readout lslr_readout_inst (
    .mclk(mclk), .sys_rst(sys_rst), .lineStartPulse(lineStartPulse), .configResetN(configResetN),
    .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .adcWord(adcWord), .pixelSel(pixelSel),
    .offsetLevel(offsetLevel), .integrating(integrating), .readoutOn(readoutOn), .videoWord(videoWord),
    .wordValid(wordValid), .pixStrobe(pixStrobe), .lineSync(lineSync)
  );

  lslr_ctrl_model ctrl_inst (
    .mclk(mclk), .lineStartPulse(lineStartPulse), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso)
  );

  // converter stand-in: a per-line salted ramp so order slips show up
  function automatic logic [11:0] adcOf(input int p);
    return 12'((p * 13 + salt) % 4096);
  endfunction

  always @(posedge mclk) adcWord <= adcOf(int'(pixelSel));

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input int idx, input logic [7:0] v);
    logic [7:0] d;
    regVal[idx] = v & regMask[idx];
    ctrl_inst.frame(regAddr[idx], 1'b1, regVal[idx], d);
  endtask

  // read every listed register plus one hole, compared with the model
  task automatic check_regs();
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      ctrl_inst.frame(regAddr[i], 1'b0, 8'h00, d);
      check(d, regVal[i], "regRead");
    end
    ctrl_inst.frame(7'h02, 1'b0, 8'h00, d);
    check(d, 8'h00, "holeRead");
  endtask

  // settled sampling: integration runs and one entry per two-clock word
  always @(negedge mclk) begin
    if (integrating === 1'b1) intRun++;
    else if (intRun > 0) begin
      intLens.push_back(intRun);
      intRun = 0;
    end
    if (wordValid === 1'b1) begin
      if (!inVideo) begin
        inVideo = 1;
        phase = 0;
        check(lineSync, 1'b1, "lineSync");
        check(16'(ctrl_inst.cyc - ctrl_inst.riseCyc inside {[296:304]}), 1, "firstWordDelay");
      end
      else check(pixStrobe ^ lastStrobe, 1'b1, "pixStrobe");
      if (phase == 0) got.push_back(videoWord);
      phase ^= 1'b1;
      if (integrating === 1'b1) overlap = 1;
      check(readoutOn, 1'b1, "readoutOnVideo");
    end
    else inVideo = 0;
    lastStrobe = pixStrobe;
  end

  // configure a window, run one line, compare words and integration span
  task automatic run_line(input int st, input int cnt, input int sk, input int md);
    int lowSeen;
    int k;
    int p;
    wr(0, 8'(md));
    wr(1, 8'(st >> 8));
    wr(2, 8'(st));
    wr(3, 8'(cnt >> 8));
    wr(4, 8'(cnt));
    wr(5, 8'(sk));
    check(readoutOn, md ? 1'b0 : 1'b1, "readoutOnIdle");
    salt = $random(seed) & 32'h0fff;
    expWords.delete();
    got.delete();
    overlap = 0;
    for (int i = 0; i < cnt; i++) begin
      p = st + i * (1 + sk);
      if (p >= 1024) break;
      expWords.push_back(adcOf(p));
    end
    ctrl_inst.rise(64 + ($random(seed) & 63), cnt, lowSeen);
    ctrl_inst.fall();
    k = 0;
    while (k < 3000 && !(k > 200 && wordValid !== 1'b1)) begin
      @(posedge mclk);
      k++;
    end
    check(16'(got.size()), 16'(expWords.size()), "wordCount");
    for (int i = 0; i < got.size() && i < expWords.size(); i++)
      check(got[i], expWords[i], "videoWord");
    if (expWords.size() > 0) check(overlap, 1'b1, "overlap");
    check(16'(intLens.size()), 16'h0001, "intCount");
    if (intLens.size() > 0) check(16'(intLens.pop_front()), 16'(lowSeen + 43), "integration");
  endtask

  // hang guard, well beyond the expected run of about 25k clocks
  initial begin
    #500000;
    miscompares++;
    print_verdict();
  end

  initial begin
    regVal = regRst;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    ctrl_inst.ticks(8);
    check(offsetLevel, 4'h7, "offsetLevel");
    check_regs();
    for (int i = 0; i < 7; i++) wr(i, 8'($random(seed)));
    check_regs();
    check(offsetLevel, regVal[6], "offsetLevel");
    configResetN <= 1'b0;
    ctrl_inst.ticks(12);
    configResetN <= 1'b1;
    ctrl_inst.ticks(8);
    regVal = regRst;
    check_regs();
    ctrl_inst.fall();
    for (int c = 0; c < 5; c++) run_line(caseSt[c], caseCnt[c], caseSk[c], c % 2);
    run_line(7, 0, 2, 1);
    print_verdict();
  end
endmodule
